// [flash_write_map_and_lock_control_tb.sv]
`timescale 1ns/10ps
`include "fwml_defs.svh"
module flash_write_map_and_lock_control_tb;
    logic        clk = 1'b0;
    logic        rst_n;
    logic        req, wr, fetch, boot, seg1, en, pd, wake, slow;
    logic        rvalid, trap, off, rdy, start, abort, t, lk;
    logic [23:0] addr;
    logic [15:0] wdata, oerr, rdata, tnum, arr_d, d;
    logic [1:0]  be;
    logic [15:0] rm [int];
    logic [23:0] ra [6] = '{`FWML_CTRL_LO, `FWML_CTRL_HI, `FWML_NVWP_ADDR,
        `FWML_NVAPA_ADDR, `FWML_NVAPB_ADDR, 24'h08dfbe};
    logic [23:0] wa [6] = '{24'h080008, 24'h08000a, 24'h08000c,
        24'h08000e, 24'h080010, 24'h080012};
    // {boot, seg1, fetch, trap, address}
    logic [27:0] mt [9] = '{{4'b0001, 24'h050000}, {4'b0000, 24'h04fffe},
        {4'b0000, 24'h002000}, {4'b0001, 24'h010000},
        {4'b0100, 24'h010000}, {4'b1010, 24'h000000},
        {4'b1011, 24'h020000}, {4'b1000, 24'h020000},
        {4'b0111, 24'h000000}};
    int          error_cnt = 0;
    int          checks = 0;
    int          cyc = 0;
    int          n;
    always #2.5 clk = ~clk;
    fwml_array_model u_arr (.clk_i(clk), .addr_i(addr), .off_i(off),
        .rdata_o(arr_d));
    fwml_ctrl uut
    (
        .core_clk_i(clk), .arst_n_i(rst_n), .req_i(req), .wr_i(wr),
        .fetch_i(fetch), .addr_i(addr), .be_i(be), .wdata_i(wdata),
        .array_rdata_i(arr_d), .boot_i(boot),
        .segment1_map_select_i(seg1), .onchip_memory_enable_i(en),
        .power_down_instruction_i(pd), .wake_i(wake),
        .supply_low_i(slow), .op_error_i(oerr), .rdata_o(rdata),
        .rvalid_o(rvalid), .trap_o(trap), .trap_num_o(tnum),
        .array_off_o(off), .array_ready_o(rdy), .prog_start_o(start),
        .prog_abort_o(abort)
    );
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic cmp16(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic cmp1(input logic g, input logic e);
        checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t flag %b exp %b", $time, g, e);
        end
    endtask
    task automatic wr16(input logic [23:0] a, input logic [15:0] v,
                        input logic [1:0] b);
        @(negedge clk);
        req = 1'b1;
        wr = 1'b1;
        addr = a;
        wdata = v;
        be = b;
        if (!lk && rm.exists(a) && a != `FWML_CTRL_LO)
        begin
            if (b[0]) rm[a][7:0] = v[7:0];
            if (b[1]) rm[a][15:8] = v[15:8];
        end
        @(negedge clk);
        req = 1'b0;
    endtask
    task automatic rd16(input logic [23:0] a, input logic f);
        @(negedge clk);
        req = 1'b1;
        wr = 1'b0;
        fetch = f;
        addr = a;
        @(negedge clk);
        req = 1'b0;
        fetch = 1'b0;
        cmp1(rvalid, en);
        d = rdata;
        t = trap;
    endtask
    task automatic rreg(input logic [23:0] a);
        rd16(a, 1'b0);
        cmp16(d, lk ? `FWML_INVALID_DATA : rm[a]);
        cmp1(t, lk);
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc > 6000)
        begin
            error_cnt++;
            conclude();
        end
    end
    initial
    begin
        void'($urandom(32'h9059));
        {rst_n, req, wr, fetch, boot, seg1, pd, wake, slow, lk} = '0;
        en = 1'b1;
        addr = '0;
        wdata = '0;
        be = 2'b11;
        oerr = 16'($urandom);
        foreach (ra[i]) rm[ra[i]] = i < 2 ? `FWML_CTRL_RST : `FWML_PROT_RST;
        foreach (wa[i]) rm[wa[i]] = '0;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        wr16(`FWML_CTRL_LO, 16'hffff, 2'b11);
        foreach (ra[i]) rreg(ra[i]);
        $display("reset values done");
        foreach (wa[i])
        begin
            wr16(wa[i], 16'($urandom), 2'b11);
            wr16(wa[i], 16'($urandom), 2'($urandom_range(2, 1)));
        end
        wr16(24'h080016, 16'h0000, 2'b11);
        foreach (wa[i]) rreg(wa[i]);
        $display("register access done");
        // Indirect register writes, no fetch from the array meanwhile
        wr16(`FWML_CTRL_HI, 16'ha000, 2'b11);
        lk = 1'b1;
        rd16(`FWML_CTRL_LO, 1'b0);
        // Busy is masked while locked; only the lock bit shows
        cmp16(d, 16'h0010);
        rreg(`FWML_DATA_BASE);
        wr16(`FWML_DATA_BASE, 16'h0f0f, 2'b11);
        rd16(24'h012000, 1'b0);
        cmp1(t, 1'b1);
        repeat (60)
        begin
            rd16(`FWML_CTRL_LO, 1'b0);
            if (!d[`FWML_BIT_LOCK]) break;
        end
        lk = 1'b0;
        rm[`FWML_CTRL_HI] = 16'h0000;
        rreg(`FWML_CTRL_LO);
        rreg(`FWML_CTRL_HI);
        rreg(`FWML_DATA_BASE);
        rd16(`FWML_ERR_ADDR, 1'b0);
        cmp16(d, oerr);
        $display("operation done");
        wr16(`FWML_CTRL_HI, 16'ha000, 2'b11);
        slow = 1'b1;
        n = 0;
        while (!abort && n < 10)
        begin
            @(negedge clk);
            n++;
        end
        cmp1(abort, 1'b1);
        slow = 1'b0;
        rreg(`FWML_CTRL_LO);
        $display("supply drop done");
        foreach (mt[i])
        begin
            {boot, seg1} = mt[i][27:26];
            rd16(mt[i][23:0], mt[i][25]);
            cmp1(t, mt[i][24]);
        end
        // Bootstrap array writes go by segment-1 addresses
        boot = 1'b1;
        wr16(`FWML_SEG1_BASE, 16'h1234, 2'b11);
        cmp1(trap, 1'b0);
        {boot, seg1} = 2'b00;
        $display("sector map done");
        en = 1'b0;
        rd16(`FWML_CTRL_LO, 1'b0);
        en = 1'b1;
        pd = 1'b1;
        repeat (6) @(negedge clk);
        cmp1(off, 1'b1);
        rd16(24'h002000, 1'b0);
        cmp1(t, 1'b1);
        pd = 1'b0;
        wake = 1'b1;
        n = 0;
        while (!rdy && n < 400)
        begin
            @(negedge clk);
            n++;
        end
        wake = 1'b0;
        cmp1(logic'(n <= `FWML_PD_REC_CYC + 10), 1'b1);
        rd16(24'h002000, 1'b0);
        cmp1(t, 1'b0);
        $display("power down done");
        conclude();
    end
endmodule

// [fwml_array_model.sv]
`timescale 1ns/10ps
module fwml_array_model
(
    input  wire logic        clk_i,
    input  wire logic [23:0] addr_i,
    input  wire logic        off_i,
    output logic [15:0]      rdata_o
);
    logic [15:0] junk_r = 16'h5a5a;
    // Switched-off array shows churn, never the last word
    always_ff @(posedge clk_i)
        junk_r <= ~junk_r + 16'h0001;
    assign rdata_o = off_i ? junk_r : (addr_i[15:0] ^ addr_i[23:8]);
endmodule

// [fwml_ctrl.sv]
`timescale 1ns/10ps
`include "fwml_defs.svh"
module fwml_ctrl
(
    input  wire logic        core_clk_i,
    input  wire logic        arst_n_i,
    input  wire logic        req_i,
    input  wire logic        wr_i,
    input  wire logic        fetch_i,
    input  wire logic [23:0] addr_i,
    input  wire logic [1:0]  be_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic [15:0] array_rdata_i,
    input  wire logic        boot_i,
    input  wire logic        segment1_map_select_i,
    input  wire logic        onchip_memory_enable_i,
    input  wire logic        power_down_instruction_i,
    input  wire logic        wake_i,
    input  wire logic        supply_low_i,
    input  wire logic [15:0] op_error_i,
    output logic [15:0]      rdata_o,
    output logic             rvalid_o,
    output logic             trap_o,
    output logic [15:0]      trap_num_o,
    output logic             array_off_o,
    output logic             array_ready_o,
    output logic             prog_start_o,
    output logic             prog_abort_o
);
    typedef struct packed
    {
        fwml_pkg::fwml_state_t st;
        logic        lock;
        logic        busy;
        logic [15:0] ctl_hi;
        logic [15:0] ctl1_lo;
        logic [15:0] ctl1_hi;
        logic [63:0] data;
        logic [31:0] tgt;
        logic [15:0] err;
        logic [15:0] nvwp;
        logic [15:0] nvapa;
        logic [31:0] nvapb;
        logic [15:0] vunp;
        logic [15:0] wake_cnt;
        logic [15:0] rdata;
        logic        rvalid;
        logic        trap;
        logic        off;
        logic        ready;
        logic        start;
        logic        abort;
        logic        pd_s1;
        logic        pd_s2;
        logic        sl_s1;
        logic        sl_s2;
    } fwml_state_s_t;
    fwml_state_s_t s_r;
    fwml_state_s_t s_nxt;
    fwml_pkg::fwml_area_t area;
    logic                 deny;
    logic                 tmr_done;
    logic                 tmr_load;

    // Byte-lane merge, shared by every writable register
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [15:0] wd,
                                            input logic [1:0]  be);
        merge16 = old;
        if (be[0])
            merge16[7:0] = wd[7:0];
        if (be[1])
            merge16[15:8] = wd[15:8];
    endfunction

    fwml_sector_map u_map
    (
        .addr_i     (addr_i),
        .fetch_i    (fetch_i),
        .write_i    (wr_i),
        .boot_i     (boot_i),
        .seg1_sel_i (segment1_map_select_i),
        .area_o     (area),
        .deny_o     (deny)
    );

    fwml_op_timer u_tmr
    (
        .core_clk_i (core_clk_i),
        .arst_n_i   (arst_n_i),
        .load_i     (tmr_load),
        .run_i      (s_r.st == fwml_pkg::FWML_RUN),
        .cycles_i   (`FWML_OP_CYCLES),
        .done_o     (tmr_done)
    );

    logic        is_reg;
    logic        is_lockbit;
    logic        is_prot;
    logic        acc;
    logic [15:0] ctl_lo_v;
    always_comb
    begin
        is_reg = (addr_i >= `FWML_CTRL_BASE) && (addr_i <= `FWML_ERR_ADDR + 24'h000001); // [R6]
        is_lockbit = (addr_i == `FWML_CTRL_LO);
        is_prot = (addr_i == `FWML_NVWP_ADDR) || (addr_i == `FWML_NVAPA_ADDR)
               || (addr_i == `FWML_NVAPB_ADDR)
               || (addr_i == `FWML_NVAPB_ADDR + 24'h000002); // [R7]
        acc = req_i && onchip_memory_enable_i; // [R11]
        ctl_lo_v = 16'h0000;
        ctl_lo_v[`FWML_BIT_LOCK] = s_r.lock;
        ctl_lo_v[`FWML_BIT_BUSY] = s_r.busy;
    end

    always_comb
    begin
        s_nxt        = s_r;
        s_nxt.rvalid = 1'b0;
        s_nxt.trap   = 1'b0;
        s_nxt.start  = 1'b0;
        s_nxt.abort  = 1'b0;
        s_nxt.pd_s1  = power_down_instruction_i;
        s_nxt.pd_s2  = s_r.pd_s1;
        s_nxt.sl_s1  = supply_low_i;
        s_nxt.sl_s2  = s_r.sl_s1;
        tmr_load     = 1'b0;
        // Read access: registers and array
        if (acc && !wr_i)
        begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata  = 16'h0000;
            if (is_reg && s_r.lock && !is_lockbit)
            begin
                s_nxt.rdata = `FWML_INVALID_DATA; // [R16]
                s_nxt.trap  = 1'b1; // [R16]
            end
            else if (is_reg)
            begin
                case (addr_i[4:1])
                    4'h0: s_nxt.rdata = s_r.lock ? (ctl_lo_v &
                              16'h0010) : ctl_lo_v; // [R17]
                    4'h1: s_nxt.rdata = s_r.ctl_hi;
                    4'h2: s_nxt.rdata = s_r.ctl1_lo;
                    4'h3: s_nxt.rdata = s_r.ctl1_hi;
                    4'h4: s_nxt.rdata = s_r.data[15:0];
                    4'h5: s_nxt.rdata = s_r.data[31:16];
                    4'h6: s_nxt.rdata = s_r.data[47:32];
                    4'h7: s_nxt.rdata = s_r.data[63:48];
                    4'h8: s_nxt.rdata = s_r.tgt[15:0];
                    4'h9: s_nxt.rdata = s_r.tgt[31:16];
                    4'ha: s_nxt.rdata = s_r.err; // [R21]
                    default: s_nxt.rdata = 16'h0000;
                endcase
            end
            else if (is_prot || addr_i == `FWML_VUNP_ADDR)
            begin
                if (addr_i == `FWML_NVWP_ADDR)
                    s_nxt.rdata = s_r.nvwp;
                else if (addr_i == `FWML_NVAPA_ADDR)
                    s_nxt.rdata = s_r.nvapa;
                else if (addr_i == `FWML_NVAPB_ADDR)
                    s_nxt.rdata = s_r.nvapb[15:0];
                else if (addr_i == `FWML_VUNP_ADDR)
                    s_nxt.rdata = s_r.vunp;
                else
                    s_nxt.rdata = s_r.nvapb[31:16];
            end
            else if (s_r.busy || s_r.off || deny
                     || area == fwml_pkg::FWML_AR_NONE)
            begin
                s_nxt.rdata = `FWML_INVALID_DATA; // [R12] [R19]
                s_nxt.trap  = 1'b1; // [R19]
            end
            else
                s_nxt.rdata = array_rdata_i;
        end
        // Writes: control registers ignored while locked or busy, volatile unprotect always taken; byte lanes honoured
        if (acc && wr_i && is_reg && !s_r.lock) // [R16] [R10]
        begin
            case (addr_i[4:1])
                4'h1: s_nxt.ctl_hi  = merge16(s_r.ctl_hi, wdata_i, be_i);
                4'h2: s_nxt.ctl1_lo = merge16(s_r.ctl1_lo, wdata_i, be_i);
                4'h3: s_nxt.ctl1_hi = merge16(s_r.ctl1_hi, wdata_i, be_i);
                4'h4: s_nxt.data[15:0]  = merge16(s_r.data[15:0], wdata_i, be_i);
                4'h5: s_nxt.data[31:16] = merge16(s_r.data[31:16], wdata_i, be_i);
                4'h6: s_nxt.data[47:32] = merge16(s_r.data[47:32], wdata_i, be_i);
                4'h7: s_nxt.data[63:48] = merge16(s_r.data[63:48], wdata_i, be_i);
                4'h8: s_nxt.tgt[15:0]   = merge16(s_r.tgt[15:0], wdata_i, be_i);
                4'h9: s_nxt.tgt[31:16]  = merge16(s_r.tgt[31:16], wdata_i, be_i);
                default: s_nxt.ctl_hi = s_r.ctl_hi;
            endcase
        end
        if (acc && wr_i && addr_i == `FWML_VUNP_ADDR)
            s_nxt.vunp = merge16(s_r.vunp, wdata_i, be_i); // [R7]
        // Operation sequencing
        case (s_r.st)
            fwml_pkg::FWML_IDLE:
            begin
                if (s_nxt.ctl_hi[`FWML_BIT_START] && !s_r.ctl_hi[`FWML_BIT_START])
                begin
                    s_nxt.lock  = 1'b1; // [R15]
                    s_nxt.busy  = 1'b1; // [R18]
                    s_nxt.start = 1'b1;
                    tmr_load    = 1'b1;
                    s_nxt.st    = fwml_pkg::FWML_RUN;
                end
                else if (s_r.pd_s2)
                begin
                    s_nxt.off   = 1'b1; // [R8]
                    s_nxt.ready = 1'b0;
                    s_nxt.st    = fwml_pkg::FWML_DOWN;
                end
            end
            fwml_pkg::FWML_RUN:
            begin
                if (tmr_done)
                begin
                    if (s_r.ctl_hi[`FWML_BIT_SPR])
                        s_nxt.nvwp = s_r.nvwp & s_r.data[15:0];
                    s_nxt.ctl_hi = 16'h0000; // [R24]
                    s_nxt.busy   = 1'b0; // [R20]
                    s_nxt.lock   = 1'b0; // [R25]
                    s_nxt.err    = op_error_i; // [R21]
                    s_nxt.st     = fwml_pkg::FWML_IDLE;
                end
                else if (s_r.ctl_hi[`FWML_BIT_SUSP])
                begin
                    s_nxt.busy = 1'b0; // [R20]
                    s_nxt.lock = 1'b0; // [R25]
                    s_nxt.st   = fwml_pkg::FWML_SUSP;
                end
            end
            fwml_pkg::FWML_SUSP:
            begin
                if (!s_r.ctl_hi[`FWML_BIT_SUSP])
                begin
                    s_nxt.busy = 1'b1; // [R20]
                    s_nxt.lock = 1'b1;
                    s_nxt.st   = fwml_pkg::FWML_RUN;
                end
            end
            fwml_pkg::FWML_DOWN:
            begin
                if (wake_i)
                begin
                    s_nxt.wake_cnt = 16'(`FWML_PD_REC_CYC);
                    s_nxt.st       = fwml_pkg::FWML_WAKE;
                end
            end
            fwml_pkg::FWML_WAKE:
            begin
                // Recovery bounded well inside oscillator start-up
                if (s_r.wake_cnt <= 16'h0001)
                begin
                    s_nxt.off   = 1'b0; // [R8]
                    s_nxt.ready = 1'b1;
                    s_nxt.st    = fwml_pkg::FWML_IDLE;
                end
                else
                    s_nxt.wake_cnt = s_r.wake_cnt - 16'h0001;
            end
            default:
                s_nxt.st = fwml_pkg::FWML_IDLE;
        endcase
        // Supply drop while busy wins over the sequencing of state, busy, lock and ctl_hi
        if (s_r.sl_s2 && s_r.busy)
        begin
            s_nxt.abort  = 1'b1; // [R22]
            s_nxt.busy   = 1'b0;
            s_nxt.lock   = 1'b0;
            s_nxt.ctl_hi = 16'h0000;
            s_nxt.st     = fwml_pkg::FWML_IDLE;
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            s_r       <= '0;
            s_r.st    <= fwml_pkg::FWML_IDLE;
            s_r.nvwp  <= `FWML_PROT_RST;
            s_r.nvapa <= `FWML_PROT_RST;
            s_r.nvapb <= {`FWML_PROT_RST, `FWML_PROT_RST};
            s_r.ready <= 1'b1;
        end
        else
            s_r <= s_nxt;
    end

    assign rdata_o       = s_r.rdata;
    assign rvalid_o      = s_r.rvalid;
    assign trap_o        = s_r.trap;
    assign trap_num_o    = `FWML_TRAP_NUM;
    assign array_off_o   = s_r.off;
    assign array_ready_o = s_r.ready;
    assign prog_start_o  = s_r.start;
    assign prog_abort_o  = s_r.abort;
endmodule

// [fwml_ctrl_chk.sv]
`timescale 1ns/10ps
`include "fwml_defs.svh"
module fwml_ctrl_chk
(
    input wire logic        core_clk_i,
    input wire logic        arst_n_i,
    input wire logic        req_i,
    input wire logic        wr_i,
    input wire logic [23:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic        onchip_memory_enable_i,
    input wire logic [15:0] rdata_o,
    input wire logic        rvalid_o,
    input wire logic        trap_o,
    input wire logic [15:0] trap_num_o,
    input wire logic        array_off_o,
    input wire logic        array_ready_o,
    input wire logic        prog_start_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);
    logic rd_w;
    logic wst_w;
    assign rd_w = req_i && !wr_i && onchip_memory_enable_i;
    assign wst_w = req_i && wr_i && onchip_memory_enable_i
        && addr_i == `FWML_CTRL_HI && wdata_i[`FWML_BIT_START];
    chk_trap_code: assert property (trap_num_o == `FWML_TRAP_NUM)
        else $error("trap number wrong");
    chk_read_answer: assert property (rd_w |=> rvalid_o)
        else $error("read not answered");
    chk_no_spurious: assert property (rvalid_o |-> $past(rd_w))
        else $error("answer without read");
    chk_trap_data: assert property (trap_o |-> rvalid_o &&
        rdata_o == `FWML_INVALID_DATA)
        else $error("trap without invalid data");
    chk_lock_open: assert property (rd_w &&
        addr_i == `FWML_CTRL_LO |=> !trap_o)
        else $error("lock bit read refused");
    chk_start_cause: assert property (prog_start_o |-> $past(wst_w))
        else $error("start without start write");
    chk_lock_holds: assert property (prog_start_o |=> !prog_start_o[*8])
        else $error("restart while locked");
    chk_off_trap: assert property (array_off_o && rd_w &&
        addr_i <= `FWML_ARRAY_END |=> trap_o)
        else $error("array read while off");
    chk_off_ready: assert property (array_off_o |-> !array_ready_o)
        else $error("ready while off");
    chk_wake_bound: assert property ($fell(array_off_o) |->
        ##[0:210] array_ready_o)
        else $error("recovery too slow");
    chk_rdata_hold: assert property ($changed(rdata_o) |-> rvalid_o)
        else $error("read data moved");
endmodule
bind fwml_ctrl fwml_ctrl_chk u_chk
(
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .req_i(req_i),
    .wr_i(wr_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .onchip_memory_enable_i(onchip_memory_enable_i),
    .rdata_o(rdata_o), .rvalid_o(rvalid_o), .trap_o(trap_o),
    .trap_num_o(trap_num_o), .array_off_o(array_off_o),
    .array_ready_o(array_ready_o), .prog_start_o(prog_start_o)
);

// [fwml_defs.svh]
`ifndef FWML_DEFS_SVH
`define FWML_DEFS_SVH
// Functional notes
// [R1] Write map: sectors 0-3 8 KB from 0x10000, 4 at 0x18000, 5-7 64 KB.
// [R2] Test sector 0x0-0x1fff never user-writable; visible only in bootstrap. Code also maps it for user reads with segment1_map_select low.
// [R3] Bootstrap: fetch test sector at 0; user sectors read/write only, no fetch.
// [R4] Software writes array in bootstrap via segment-1 addresses from 0x10000.
// [R5] Bootstrap reads decode segment 0 or 1 by segment1_map_select, default 0. Code also maps segment 1 with segment1_map_select low.
// [R6] Control 0x80000, data 0x80008, address 0x80010, error 0x80014 decoded.
// [R7] Protection at 0x8dfb0/b8/bc; volatile unprotect at 0xeb50.
// [R8] Power-down turns array off; recovery within oscillator start-up time.
// [R9] Software never executes power-down during program or erase.
// [R10] Byte and word accesses accepted on every flash register.
// [R11] Software sets onchip_memory_enable before touching array or registers.
// [R12] Array reads during a write give invalid data and trap 0x009b.
// [R13] Software issues write sequences from RAM or external memory only.
// [R14] Software writes control registers with indirect addressing only.
// [R15] Register lock, control low bit 4, set when operation start is set.
// [R16] While locked, register reads trap with invalid data; writes ignored.
// [R17] Lock bit always readable; other registers accessible once it is low.
// [R18] Bank busy, control low bit 1, set by start and set-protection.
// [R19] While busy, bank reads trap with invalid data; bank writes ignored.
// [R20] Busy clears at end or suspend; set again on resume.
// [R21] Error register readable when unlocked, updated only when not busy.
// [R22] Core supply drop aborts operation and resets module to read mode. Code aborts only while busy, not while suspended.
// [R23] Software loads address, data, operation type before setting start.
// [R24] Each operation-select bit clears when its operation finishes.
// [R25] Lock clears when operation completes or is suspended.
`define FWML_ADDR_W        24
`define FWML_TEST_END      24'h001fff
`define FWML_SEG1_BASE     24'h010000
`define FWML_S4_BASE       24'h018000
`define FWML_S5_BASE       24'h020000
`define FWML_ARRAY_END     24'h04ffff
`define FWML_SEG0_END      24'h007fff
`define FWML_CTRL_BASE     24'h080000
`define FWML_CTRL_LO       24'h080000
`define FWML_CTRL_HI       24'h080002
`define FWML_DATA_BASE     24'h080008
`define FWML_ADDR_BASE     24'h080010
`define FWML_ERR_ADDR      24'h080014
`define FWML_NVWP_ADDR     24'h08dfb0
`define FWML_NVAPA_ADDR    24'h08dfb8
`define FWML_NVAPB_ADDR    24'h08dfbc
`define FWML_VUNP_ADDR     24'h00eb50
`define FWML_BIT_BUSY      1
`define FWML_BIT_LOCK      4
`define FWML_BIT_START     15
`define FWML_BIT_SUSP      14
`define FWML_BIT_WPG       13
`define FWML_BIT_DWPG      12
`define FWML_BIT_SER       11
`define FWML_BIT_SPR       8
`define FWML_TRAP_NUM      16'h009b
`define FWML_INVALID_DATA  16'hffff
`define FWML_CTRL_RST      16'h0000
`define FWML_PROT_RST      16'hffff
`define FWML_OP_CYCLES     16'h0040
`define FWML_PD_REC_NS     1000
`define FWML_CLK_NS        5
`define FWML_PD_REC_CYC    ((`FWML_PD_REC_NS + `FWML_CLK_NS - 1) / `FWML_CLK_NS)
`endif

// [fwml_op_timer.sv]
`timescale 1ns/10ps
`include "fwml_defs.svh"
module fwml_op_timer
(
    input  wire logic        core_clk_i,
    input  wire logic        arst_n_i,
    input  wire logic        load_i,
    input  wire logic        run_i,
    input  wire logic [15:0] cycles_i,
    output logic             done_o
);
    typedef struct packed
    {
        logic [15:0] cnt;
        logic        done;
    } fwml_tmr_t;
    fwml_tmr_t st_r;
    fwml_tmr_t st_nxt;
    always_comb
    begin
        st_nxt      = st_r;
        st_nxt.done = 1'b0;
        if (load_i)
            st_nxt.cnt = cycles_i;
        else if (run_i && st_r.cnt != 16'h0000)
        begin
            st_nxt.cnt  = st_r.cnt - 16'h0001;
            st_nxt.done = (st_r.cnt == 16'h0001);
        end
    end
    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end
    assign done_o = st_r.done;
endmodule

// [fwml_pkg.sv]
package fwml_pkg;
    typedef enum logic [2:0] {
        FWML_IDLE  = 3'b000,
        FWML_RUN   = 3'b001,
        FWML_SUSP  = 3'b010,
        FWML_DOWN  = 3'b011,
        FWML_WAKE  = 3'b100
    } fwml_state_t;
    typedef enum logic [1:0] {
        FWML_AR_NONE = 2'b00,
        FWML_AR_TEST = 2'b01,
        FWML_AR_USER = 2'b10
    } fwml_area_t;
endpackage

// [fwml_sector_map.sv]
`timescale 1ns/10ps
`include "fwml_defs.svh"
module fwml_sector_map
(
    input  wire logic [23:0]        addr_i,
    input  wire logic               fetch_i,
    input  wire logic               write_i,
    input  wire logic               boot_i,
    input  wire logic               seg1_sel_i,
    output fwml_pkg::fwml_area_t    area_o,
    output logic                    deny_o
);
    logic in_seg0;
    logic in_seg1;
    logic in_test;
    always_comb
    begin
        in_test = (addr_i <= `FWML_TEST_END);
        in_seg0 = (addr_i <= `FWML_SEG0_END);
        in_seg1 = (addr_i >= `FWML_SEG1_BASE) && (addr_i <= `FWML_ARRAY_END); // [R1]
        area_o  = fwml_pkg::FWML_AR_NONE;
        deny_o  = 1'b0;
        if (boot_i && fetch_i)
        begin
            if (in_test)
                area_o = fwml_pkg::FWML_AR_TEST; // [R3]
            else
                deny_o = 1'b1; // [R3]
        end
        else if (write_i)
        begin
            // Writes always go by the segment-1 map
            if (in_seg1)
                area_o = fwml_pkg::FWML_AR_USER; // [R1]
            else
                deny_o = 1'b1; // [R2]
        end
        else if (boot_i && !seg1_sel_i && in_seg0)
            area_o = fwml_pkg::FWML_AR_USER; // [R5]
        else if ((boot_i || seg1_sel_i) && in_seg1)
            area_o = fwml_pkg::FWML_AR_USER; // [R5]
        else if (!boot_i && !seg1_sel_i && (in_seg0 || (addr_i >= `FWML_S4_BASE
                 && addr_i <= `FWML_ARRAY_END)))
            area_o = fwml_pkg::FWML_AR_USER;
        else if (in_test)
            deny_o = 1'b1; // [R2]
    end
endmodule
